// >>> src/pmh_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Select strobe drops ready flag
// - Echo lines show newly selected program
// - Acknowledge raised; controller then drops strobe
// - Ready returns; acknowledge clears after strobe drops
// - Measuring holds pass, fail high, ready low
// - Verdict encoded on pass and fail
// - Ready high after evaluation without logging
// - Request drop ignored unless external stop
// - PC logging holds ready until transfer done
// - Host logging output high when host mode control bit set
// - USB logging start: internal or request input
// - Acquisition output high; its fall starts evaluation
// - Ready waits for evaluation and USB write
// - USB failure lights lamp, withholds ready
// - First USB measurement delays ready once
// - Clearing ready control option disables USB hold
// - Zero request drops ready until zeroing done
// - Warning when sensor exceeds enabled threshold
// - Warning cleared by clean zeroing or disable
module pmh_top
  import pmh_pkg::*;
#(
  parameter int HDR_CYCLES = HDR_DELAY_CYC,
  parameter int PROG_WIDTH = PROG_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [PROG_WIDTH-1:0] i_program_select_lines,
  input wire logic i_select_strobe,
  input wire logic i_measure_request,
  input wire logic i_zero_request,
  output logic [PROG_WIDTH-1:0] o_program_echo_lines,
  output logic o_select_ack,
  output logic o_ready,
  output logic o_result_pass,
  output logic o_result_fail,
  output logic o_host_logging_active,
  output logic o_acquisition_active,
  output logic o_error_lamp,
  output logic o_zero_warning,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import pmh_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (PROG_WIDTH < 1 || PROG_WIDTH > 16) begin : g_bad_width
    $error("PROG_WIDTH out of range");
  end
  if (HDR_CYCLES < 1) begin : g_bad_hdr
    $error("HDR_CYCLES must be positive");
  end

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  localparam int SW = PROG_WIDTH + 3;
  logic [SW-1:0] sync_out;
  logic [PROG_WIDTH-1:0] prog_s;
  logic strobe_s;
  logic meas_s;
  logic zero_s;
  logic meas_d_ff;
  logic zero_d_ff;
  logic meas_rise;
  logic meas_fall;
  logic zero_rise;

  pmh_sync #(.WIDTH(SW)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_program_select_lines, i_select_strobe, i_measure_request, i_zero_request}),
    .o_sync(sync_out)
  );
  assign prog_s = sync_out[SW-1:3];
  assign strobe_s = sync_out[2];
  assign meas_s = sync_out[1];
  assign zero_s = sync_out[0];
  assign meas_rise = meas_s & ~meas_d_ff;
  assign meas_fall = ~meas_s & meas_d_ff;
  assign zero_rise = zero_s & ~zero_d_ff;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] thresh_ff;
  logic [31:0] sensor_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] rd_addr;
  logic addr_valid;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_thresh;
  logic wr_sensor;
  logic [31:0] cmd;
  logic [31:0] status_word;
  logic [31:0] nxt_hrdata;
  logic [31:0] hrdata_ff;

  assign addr_valid = hsel & hready & htrans[1];
  assign rd_addr = haddr[7:0];
  assign wr_ctrl = wr_pend_ff & (wr_addr_ff == ADDR_CTRL);
  assign wr_cmd = wr_pend_ff & (wr_addr_ff == ADDR_CMD);
  assign wr_thresh = wr_pend_ff & (wr_addr_ff == ADDR_THRESH);
  assign wr_sensor = wr_pend_ff & (wr_addr_ff == ADDR_SENSOR);
  assign cmd = wr_cmd ? hwdata : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_valid & hwrite;
      wr_addr_ff <= rd_addr;
      hrdata_ff <= (addr_valid & ~hwrite) ? nxt_hrdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= CTRL_RESET;
      thresh_ff <= THRESH_RESET;
      sensor_ff <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_ff <= hwdata;
      if (wr_thresh) thresh_ff <= hwdata;
      if (wr_sensor) sensor_ff <= hwdata;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  pmh_state_t state_ff;
  pmh_state_t nxt_state;
  logic [PROG_WIDTH-1:0] echo_ff;
  logic ack_ff;
  logic pass_ff;
  logic fail_ff;
  logic err_ff;
  logic warn_ff;
  logic hdr_done_ff;
  logic zero_done_ff;
  logic [31:0] hdr_cnt_ff;
  logic ext_stop;
  logic usb_hold;
  logic start_req;
  logic stop_req;
  logic warn_hit;
  logic ready;

  assign ext_stop = ctrl_ff[CTRL_EXT_STOP];
  assign usb_hold = ctrl_ff[CTRL_USB_LOG] & ctrl_ff[CTRL_RDY_CTRL];
  assign start_req = (ctrl_ff[CTRL_USB_LOG] & ctrl_ff[CTRL_INT_START]) ? cmd[CMD_INT_START] : meas_rise;
  assign stop_req = ext_stop ? meas_fall : cmd[CMD_INT_STOP];
  assign warn_hit = ctrl_ff[CTRL_WARN_EN] & (sensor_ff > thresh_ff);
  assign ready = (state_ff == ST_IDLE);

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign o_ready = ready;
  assign o_select_ack = ack_ff;
  assign o_program_echo_lines = echo_ff;
  assign o_result_pass = pass_ff;
  assign o_result_fail = fail_ff;
  assign o_acquisition_active = (state_ff == ST_ACQUIRE);
  assign o_host_logging_active = ctrl_ff[CTRL_HOST_MODE];
  assign o_error_lamp = err_ff;
  assign o_zero_warning = warn_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (strobe_s && !ack_ff) begin
          nxt_state = ST_SELECT;
        end else if (start_req) begin
          nxt_state = ST_ACQUIRE;
        end else if (zero_rise && ctrl_ff[CTRL_ZERO_EN]) begin
          nxt_state = ST_ZERO;
        end
      end
      ST_SELECT: begin
        if (cmd[CMD_SEL_DONE]) nxt_state = ST_SEL_ACK;
      end
      ST_SEL_ACK: begin
        if (!strobe_s) nxt_state = ST_IDLE;
      end
      ST_ACQUIRE: begin
        if (stop_req) nxt_state = ST_EVAL;
      end
      ST_EVAL: begin
        if (cmd[CMD_EVAL_DONE]) begin
          if (ctrl_ff[CTRL_PC_LOG] || usb_hold) nxt_state = ST_LOG;
          else nxt_state = ST_IDLE;
        end
      end
      ST_LOG: begin
        if (usb_hold && cmd[CMD_USB_ERR]) begin
          nxt_state = ST_ERROR;
        end else if ((!ctrl_ff[CTRL_PC_LOG] || cmd[CMD_PC_DONE]) && (!usb_hold || cmd[CMD_USB_DONE])) begin
          nxt_state = (usb_hold && !hdr_done_ff) ? ST_HEADER : ST_IDLE;
        end
      end
      ST_HEADER: begin
        if (hdr_cnt_ff == 32'(HDR_CYCLES - 1)) nxt_state = ST_IDLE;
      end
      ST_ZERO: begin
        if ((cmd[CMD_ZERO_DONE] || zero_done_ff) && !zero_s) nxt_state = ST_IDLE;
      end
      ST_ERROR: begin
        if (cmd[CMD_ERR_CLR]) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      meas_d_ff <= 1'b0;
      zero_d_ff <= 1'b0;
      hdr_cnt_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      meas_d_ff <= meas_s;
      zero_d_ff <= zero_s;
      hdr_cnt_ff <= (state_ff == ST_HEADER) ? hdr_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      echo_ff <= '0;
      ack_ff <= 1'b0;
    end else begin
      if (state_ff == ST_SELECT) echo_ff <= prog_s;
      if (nxt_state == ST_SEL_ACK) ack_ff <= 1'b1;
      else if (!strobe_s) ack_ff <= 1'b0;
    end
  end

  // Done command kept until the zero request is released
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_done_ff <= 1'b0;
    end else if (state_ff != ST_ZERO) begin
      zero_done_ff <= 1'b0;
    end else if (cmd[CMD_ZERO_DONE]) begin
      zero_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Result outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else if (nxt_state == ST_ACQUIRE) begin
      pass_ff <= 1'b1;
      fail_ff <= 1'b1;
    end else if (state_ff == ST_EVAL && cmd[CMD_EVAL_DONE]) begin
      pass_ff <= hwdata[CMD_VERDICT];
      fail_ff <= ~hwdata[CMD_VERDICT];
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      err_ff <= 1'b0;
    end else if (nxt_state == ST_ERROR) begin
      err_ff <= 1'b1;
    end else if (cmd[CMD_ERR_CLR]) begin
      err_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hdr_done_ff <= 1'b0;
    end else if (state_ff == ST_HEADER) begin
      hdr_done_ff <= 1'b1;
    end else if (!ctrl_ff[CTRL_USB_LOG]) begin
      hdr_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      warn_ff <= 1'b0;
    end else if (!ctrl_ff[CTRL_ZERO_EN]) begin
      warn_ff <= 1'b0;
    end else if (state_ff == ST_ZERO) begin
      warn_ff <= warn_hit;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  assign status_word = {16'h0000, 4'h0, 4'(echo_ff), warn_ff, err_ff, fail_ff, pass_ff,
                        ack_ff, o_acquisition_active, ready, hdr_done_ff};

  always_comb begin
    case (rd_addr)
      ADDR_CTRL: nxt_hrdata = ctrl_ff;
      ADDR_STATUS: nxt_hrdata = status_word;
      ADDR_THRESH: nxt_hrdata = thresh_ff;
      ADDR_SENSOR: nxt_hrdata = sensor_ff;
      ADDR_HDR_CNT: nxt_hrdata = hdr_cnt_ff;
      default: nxt_hrdata = 32'h0000_0000;
    endcase
  end
endmodule // pmh_top

// >>> src/pmh_pkg.sv
package pmh_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_THRESH = 8'h0C;
  localparam logic [7:0] ADDR_SENSOR = 8'h10;
  localparam logic [7:0] ADDR_HDR_CNT = 8'h14;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTRL_EXT_STOP = 0;
  localparam int CTRL_PC_LOG = 1;
  localparam int CTRL_USB_LOG = 2;
  localparam int CTRL_RDY_CTRL = 3;
  localparam int CTRL_INT_START = 4;
  localparam int CTRL_ZERO_EN = 5;
  localparam int CTRL_WARN_EN = 6;
  localparam int CTRL_HOST_MODE = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0029;
  // ----------------------------------------
  // Command fields (write-one pulses, except the verdict data bit)
  // ----------------------------------------
  localparam int CMD_INT_START = 0;
  localparam int CMD_INT_STOP = 1;
  localparam int CMD_EVAL_DONE = 2;
  localparam int CMD_VERDICT = 3;
  localparam int CMD_PC_DONE = 4;
  localparam int CMD_USB_DONE = 5;
  localparam int CMD_USB_ERR = 6;
  localparam int CMD_ZERO_DONE = 7;
  localparam int CMD_ERR_CLR = 8;
  localparam int CMD_SEL_DONE = 9;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int HDR_DELAY_MS = 1500;
  localparam int HDR_DELAY_CYC = HDR_DELAY_MS * CLK_MHZ * 1000;
  localparam int SYNC_STAGES = 2;
  localparam int PROG_W = 4;
  localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
  typedef enum {
    ST_IDLE, ST_SELECT, ST_SEL_ACK, ST_ACQUIRE, ST_EVAL, ST_LOG, ST_HEADER, ST_ZERO, ST_ERROR
  } pmh_state_t;
endpackage

// >>> src/pmh_sync.sv
`timescale 1ns/1ps
module pmh_sync #(
  parameter int WIDTH = 7
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end
  assign o_sync = sync_ff;
endmodule // pmh_sync

// >>> test/pmh_top_asserts.sv
`timescale 1ns/1ps
module pmh_top_asserts #(
  parameter int PROG_WIDTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_select_strobe,
  input wire logic i_zero_request,
  input wire logic [PROG_WIDTH-1:0] o_program_echo_lines,
  input wire logic o_select_ack,
  input wire logic o_ready,
  input wire logic o_result_pass,
  input wire logic o_result_fail,
  input wire logic o_acquisition_active,
  input wire logic o_error_lamp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_acq_outputs: assert property (
    o_acquisition_active |-> o_result_pass && o_result_fail && !o_ready) else $error("acq outputs");
  chk_eval_start: assert property (
    $fell(o_acquisition_active) |-> !o_ready) else $error("eval ready");
  chk_sel_ready: assert property (
    $rose(i_select_strobe) && o_ready |-> ##[1:6] !o_ready) else $error("select ready");
  chk_ack_ready: assert property (
    $rose(o_select_ack) |-> !o_ready) else $error("ack ready");
  chk_ack_hold: assert property (
    o_select_ack && i_select_strobe |=> o_select_ack) else $error("ack hold");
  chk_echo_idle: assert property (
    o_ready && $past(o_ready) |-> $stable(o_program_echo_lines)) else $error("echo idle");
  chk_zero_ready: assert property (
    $rose(i_zero_request) && o_ready |-> ##[1:6] !o_ready) else $error("zero ready");
  chk_lamp_ready: assert property (
    o_error_lamp && $past(o_error_lamp) |-> !o_ready) else $error("lamp ready");
endmodule // pmh_top_asserts
bind pmh_top pmh_top_asserts #(.PROG_WIDTH(PROG_WIDTH)) pmh_top_asserts_i (.*);

// >>> test/pmh_plc_model.sv
`timescale 1ns/1ps
module pmh_plc_model (
  input wire logic i_core_clk,
  input wire logic i_ready,
  input wire logic i_ack,
  output logic [3:0] o_prog = 4'h0,
  output logic o_strobe = 1'b0,
  output logic o_meas = 1'b0,
  output logic o_zero = 1'b0
);
  task automatic wt(input logic a, input logic x);
    for (int n = 0; n < 200 && (a ? i_ack : i_ready) !== x; n++) @(posedge i_core_clk);
  endtask
  task automatic sel_begin(input logic [3:0] p);
    wt(1'b0, 1'b1);
    o_prog <= p;
    @(posedge i_core_clk);
    o_strobe <= 1'b1;
  endtask
  task automatic sel_end(input int lag);
    wt(1'b1, 1'b1);
    repeat (lag) @(posedge i_core_clk);
    o_strobe <= 1'b0;
  endtask
  task automatic meas(input logic x);
    if (x) wt(1'b0, 1'b1);
    o_meas <= x;
  endtask
  task automatic zero();
    wt(1'b0, 1'b1);
    o_zero <= 1'b1;
    wt(1'b0, 1'b0);
    o_zero <= 1'b0;
  endtask
endmodule // pmh_plc_model

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pmh_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, hwrite = 1'b0, hsel = 1'b0, hready, hreadyout, hresp;
  logic i_select_strobe, i_measure_request, i_zero_request, o_select_ack, o_ready, o_result_pass, o_result_fail;
  logic o_host_logging_active, o_acquisition_active, o_error_lamp, o_zero_warning;
  logic [3:0] i_program_select_lines, o_program_echo_lines, p;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, ctl, th, rnd = 32'hA1F2908D;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  int fail_count = 0, checked = 0;
  assign hready = hreadyout;
  pmh_top #(.HDR_CYCLES(20)) pmh_top_i (.*);
  pmh_plc_model pmh_plc_model_i (.i_core_clk, .i_ready(o_ready), .i_ack(o_select_ack),
    .o_prog(i_program_select_lines), .o_strobe(i_select_strobe), .o_meas(i_measure_request), .o_zero(i_zero_request));
  initial forever #5 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic warn_exp(input logic [31:0] t, input logic [31:0] s);
    return s > t;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    conclude();
  endtask
  initial begin
    #900000;
    hang();
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge i_core_clk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge i_core_clk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50) hang();
    repeat (2) @(posedge i_core_clk);
  endtask
  task automatic cmd(input int b);
    bus(1'b1, ADDR_CMD, 32'h1 << b);
  endtask
  task automatic waitr(input logic x);
    int n;
    for (n = 0; n < 200 && o_ready !== x; n++) @(posedge i_core_clk);
    if (n == 200) hang();
  endtask
  task automatic meas(input logic s, input logic e, input logic r);
    if (s) pmh_plc_model_i.meas(1'b1);
    else cmd(CMD_INT_START);
    waitr(1'b0);
    chk("acq", 1, o_acquisition_active);
    chk("both", 2'b11, {o_result_pass, o_result_fail});
    pmh_plc_model_i.meas(1'b0);
    repeat (6) @(posedge i_core_clk);
    chk("acq_drop", !e, o_acquisition_active);
    if (!e) cmd(CMD_INT_STOP);
    bus(1'b1, ADDR_CMD, (32'h1 << CMD_EVAL_DONE) | (32'(r) << CMD_VERDICT));
    chk("verdict", {r, !r}, {o_result_pass, o_result_fail});
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    chk("ready_rst", 1, o_ready);
    chk("outs_rst", 0, {o_select_ack, o_result_pass, o_result_fail, o_acquisition_active, o_error_lamp});
    bus(1'b0, ADDR_CTRL, 0);
    chk("ctrl_rst", CTRL_RESET, rd);
    chk("hresp", 0, hresp);
    bus(1'b0, 8'h40, 0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 3; i++) begin
      rnd = nx(rnd);
      p = (i == 0) ? 4'hF : rnd[3:0];
      pmh_plc_model_i.sel_begin(p);
      waitr(1'b0);
      cmd(CMD_SEL_DONE);
      chk("ack", 1, o_select_ack);
      chk("echo", p, o_program_echo_lines);
      pmh_plc_model_i.sel_end(i);
      waitr(1'b1);
      repeat (3) @(posedge i_core_clk);
      chk("ack_clr", 0, o_select_ack);
    end
    $display("select done");
    for (int i = 0; i < 2; i++) begin
      rnd = nx(rnd);
      meas(1'b1, 1'b1, rnd[0]);
      waitr(1'b1);
    end
    bus(1'b1, ADDR_CTRL, CTRL_RESET & ~32'h1);
    meas(1'b1, 1'b0, rnd[1]);
    waitr(1'b1);
    ctl = CTRL_RESET | (32'h1 << CTRL_PC_LOG) | (32'h1 << CTRL_HOST_MODE);
    bus(1'b1, ADDR_CTRL, ctl);
    chk("host_log", 1, o_host_logging_active);
    meas(1'b1, 1'b1, rnd[2]);
    repeat (10) @(posedge i_core_clk);
    chk("ready_pc", 0, o_ready);
    cmd(CMD_PC_DONE);
    waitr(1'b1);
    $display("measure done");
    ctl = (CTRL_RESET & ~32'h1) | (32'h1 << CTRL_USB_LOG) | (32'h1 << CTRL_INT_START);
    bus(1'b1, ADDR_CTRL, ctl);
    for (int i = 0; i < 3; i++) begin
      meas(1'b0, 1'b0, rnd[i]);
      repeat (5) @(posedge i_core_clk);
      chk("ready_usb", 0, o_ready);
      cmd((i == 2) ? CMD_USB_ERR : CMD_USB_DONE);
      repeat (3) @(posedge i_core_clk);
      chk("ready_hdr", i == 1, o_ready);
      chk("lamp", i == 2, o_error_lamp);
      if (i < 2) waitr(1'b1);
    end
    repeat (30) @(posedge i_core_clk);
    chk("ready_err", 0, o_ready);
    cmd(CMD_ERR_CLR);
    waitr(1'b1);
    bus(1'b1, ADDR_CTRL, ctl & ~(32'h1 << CTRL_RDY_CTRL));
    meas(1'b0, 1'b0, 1'b1);
    waitr(1'b1);
    $display("usb done");
    bus(1'b1, ADDR_CTRL, CTRL_RESET | (32'h1 << CTRL_WARN_EN));
    rnd = nx(rnd);
    th = {16'h0000, rnd[15:0]};
    bus(1'b1, ADDR_THRESH, th);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_SENSOR, th + 32'(1 - i));
      pmh_plc_model_i.zero();
      cmd(CMD_ZERO_DONE);
      waitr(1'b1);
      chk("warn", warn_exp(th, th + 32'(1 - i)), o_zero_warning);
    end
    $display("zero done");
    conclude();
  end
endmodule // testbench
